// >>> core/rtc_counter_mode0.v
// real-time counter, 32-bit counter mode, with an AXI4-Lite register bank
// assumes one clock; the source clock is an enable pulse made here by a divider
//
// Behaviour
// [R1] software sets mode, clock form, prescaler first
// [R2] calendar mode needs a one hertz counter clock
// [R3] counter clock is source over two^prescaler
// [R4] enable bit starts and stops the counter
// [R5] software reset clears all but debug, disables
// [R6] software disables before requesting software reset
// [R7] mode field: 00 is 32-bit counter
// [R8] count increments on each counter clock tick
// [R9] top value wraps to zero, sets overflow
// [R10] full 32-bit count readable and writable
// [R11] match sets compare flag next counter tick
// [R12] clear on match clears count next tick
// [R13] clear on match sets both flags together
// [R14] register decode depends on operating mode
// [R15] read request starts sync, sets busy
// [R16] sync address field is constant count offset
// [R17] flags clear by writing one; enabled raise irq
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rtc_counter_regs.vh"

module rtc_counter_mode0 #(
  parameter SRC_DIV = 1
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // axi4-lite write
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // axi4-lite read
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // events and interrupt
  output reg  [7:0]  periodic_event_out,
  output reg         compare_event_out,
  output reg         overflow_event_out,
  output reg         irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [15:0] control_register;
  reg         read_cont;
  reg  [15:0] event_output_control;
  reg  [7:0]  irq_enable;
  reg  [7:0]  irq_flag_status;
  reg         sync_in_progress;
  reg  [1:0]  sync_cnt;
  reg  [7:0]  debug_control;
  reg  [7:0]  frequency_correction;
  reg  [31:0] counter_value;
  reg  [31:0] count_snapshot;
  reg  [31:0] compare_value_0;
  reg  [15:0] presc_cnt;
  reg  [31:0] src_div_cnt;

  // ----------------------------------------------------------------
  // bus write decode
  // ----------------------------------------------------------------
  wire        wr_go  = awvalid & wvalid & ~bvalid;
  wire [5:0]  wr_idx = awaddr[7:2];
  wire [31:0] bmask  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire [31:0] wbits  = wdata & bmask;
  wire [1:0]  mode   = control_register[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire        mode0  = (mode == `MODE_COUNT32);
  wire        mode1  = (mode == `MODE_COUNT16);
  wire        wide_ok = mode0 | mode1;

  assign awready = wr_go;
  assign wready  = wr_go;
  assign arready = ~rvalid;

  wire wr_ctrl  = wr_go & (wr_idx == `IDX_CONTROL);
  wire wr_rsync = wr_go & (wr_idx == `IDX_READ_SYNC);
  wire wr_evt   = wr_go & (wr_idx == `IDX_EVENT_CTRL);
  wire wr_ienc  = wr_go & (wr_idx == `IDX_IRQ_EN_CLR);
  wire wr_iens  = wr_go & (wr_idx == `IDX_IRQ_EN_SET);
  wire wr_flag  = wr_go & (wr_idx == `IDX_IRQ_FLAG);
  wire wr_dbg   = wr_go & (wr_idx == `IDX_DEBUG_CTRL);
  wire wr_fcorr = wr_go & (wr_idx == `IDX_FREQ_CORR);
  wire wr_count = wr_go & (wr_idx == `IDX_COUNTER_VALUE) & wide_ok; // [R14]
  wire wr_comp  = wr_go & (wr_idx == `IDX_COMPARE_0) & wide_ok;     // [R14]
  wire wr_hit   = wr_ctrl | wr_rsync | wr_evt | wr_ienc | wr_iens | wr_flag |
                  wr_dbg | wr_fcorr | wr_count | wr_comp;

  // the disable-before-reset order is left to software; reset wins here anyway
  wire soft_rst = wr_ctrl & wbits[`CTRL_SOFTWARE_RESET_BIT]; // [R5] [R6]

  // only the low half of a 32-bit count kept in 16-bit mode
  wire [31:0] wide_mask = mode0 ? 32'hffffffff : 32'h0000ffff; // [R14]

  // ----------------------------------------------------------------
  // prescaler and counter clock enable
  // ----------------------------------------------------------------
  wire        run     = control_register[`CTRL_ENABLE] & mode0; // [R4] [R7]
  wire [3:0]  presc   = control_register[`CTRL_PRESC_HI:`CTRL_PRESC_LO];
  wire        src_tick = (src_div_cnt == SRC_DIV - 1);
  wire [15:0] low_ones = (16'h0001 << presc) - 16'h0001;
  wire        cnt_tick = run & src_tick & ((presc_cnt & low_ones) == low_ones); // [R3]
  wire [15:0] next_presc = presc_cnt + 16'h0001;
  wire        match    = (counter_value == compare_value_0);
  wire        clr_hit  = control_register[`CTRL_CLEAR_ON_MATCH] & match;
  wire        top      = (counter_value == 32'hffffffff);
  wire [31:0] next_count = clr_hit ? `RST_WORD : counter_value + 32'h00000001;
  wire        ovf_ev   = cnt_tick & (top | clr_hit); // [R9] [R13]
  wire        cmp_ev   = cnt_tick & match;           // [R11]
  // sync completion: the snapshot is taken on the same edge that sets the flag
  wire        sync_done_set = sync_in_progress & (sync_cnt == 2'h0);

  // ----------------------------------------------------------------
  // periodic events, one per each of the low eight prescaler stages
  // ----------------------------------------------------------------
  wire [7:0] per_rise;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_per
      assign per_rise[g] = run & src_tick & ~presc_cnt[g] & next_presc[g];
    end
  endgenerate

  always @(posedge clk) begin
    if (srst) begin
      src_div_cnt <= 32'h00000000;
    end else if (src_tick) begin
      src_div_cnt <= 32'h00000000;
    end else begin
      src_div_cnt <= src_div_cnt + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // main register and counter state
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst || soft_rst) begin // [R5]
      control_register     <= `RST_CONTROL;
      read_cont            <= 1'b0;
      event_output_control <= `RST_EVENT_CTRL;
      irq_enable           <= `RST_IRQ;
      irq_flag_status      <= `RST_IRQ;
      sync_in_progress     <= 1'b0;
      sync_cnt             <= 2'h0;
      frequency_correction <= 8'h00;
      counter_value        <= `RST_WORD;
      count_snapshot       <= `RST_WORD;
      compare_value_0      <= `RST_WORD;
      presc_cnt            <= 16'h0000;
      periodic_event_out   <= 8'h00;
      compare_event_out    <= 1'b0;
      overflow_event_out   <= 1'b0;
      irq                  <= 1'b0;
    end else begin
      // configuration order before enabling is software's duty
      if (wr_ctrl) begin // [R1] [R2] [R4] [R7]
        control_register <= (control_register & ~`CTRL_WMASK) | (wbits[15:0] & `CTRL_WMASK);
      end
      if (wr_evt) begin
        event_output_control <= (event_output_control & ~`EVT_WMASK) |
                                (wbits[15:0] & `EVT_WMASK);
      end
      if (wr_fcorr) begin
        frequency_correction <= (frequency_correction & ~bmask[7:0]) | wbits[7:0];
      end
      if (wr_iens) begin
        irq_enable <= irq_enable | (wbits[7:0] & `FLAG_MASK);
      end else if (wr_ienc) begin
        irq_enable <= irq_enable & ~(wbits[7:0] & `FLAG_MASK);
      end

      // prescaler runs only while counting
      if (!run) begin
        presc_cnt <= 16'h0000;
      end else if (src_tick) begin
        presc_cnt <= next_presc;
      end

      // counting; a bus write to the count wins over a tick
      if (wr_count) begin // [R10]
        counter_value <= (counter_value & ~(bmask & wide_mask)) | (wbits & wide_mask);
      end else if (cnt_tick) begin
        counter_value <= next_count; // [R8] [R9] [R12]
      end
      if (wr_comp) begin // [R10]
        compare_value_0 <= (compare_value_0 & ~(bmask & wide_mask)) | (wbits & wide_mask);
      end

      // flags: a hardware set in the clear cycle survives
      irq_flag_status <= (irq_flag_status & ~(wr_flag ? wbits[7:0] : 8'h00)) | // [R17]
                         {ovf_ev, sync_done_set, 5'h00, cmp_ev}; // [R9] [R11] [R13]

      // read synchronisation of the count
      if (wr_rsync) begin
        read_cont <= wbits[`RSYNC_RCONT];
      end else if (wr_hit) begin
        read_cont <= 1'b0;
      end
      if (wr_rsync && wbits[`RSYNC_READ_SYNC_REQUEST]) begin // [R15]
        sync_in_progress <= 1'b1;
        sync_cnt         <= `SYNC_CYCLES;
      end else if (sync_in_progress) begin
        if (sync_cnt == 2'h0) begin
          count_snapshot   <= counter_value;
          sync_in_progress <= read_cont; // continuous mode keeps the request alive
          sync_cnt         <= `SYNC_CYCLES;
        end else begin
          sync_cnt <= sync_cnt - 2'h1;
        end
      end

      // event outputs
      periodic_event_out <= per_rise & event_output_control[7:0];
      compare_event_out  <= cmp_ev & event_output_control[`EVT_CMPEO0];
      overflow_event_out <= ovf_ev & event_output_control[`EVT_OVERFLOW_EVENT_OUT];
      irq                <= |(irq_flag_status & irq_enable); // [R17]
    end
  end

  // debug control survives the software reset
  always @(posedge clk) begin
    if (srst) begin
      debug_control <= 8'h00;
    end else if (wr_dbg) begin
      debug_control <= (debug_control & ~(bmask[7:0] & `DBG_WMASK)) |
                       (wbits[7:0] & `DBG_WMASK); // [R5]
    end
  end

  // ----------------------------------------------------------------
  // bus write response
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // bus read path
  // ----------------------------------------------------------------
  wire [5:0]  rd_idx = araddr[7:2];
  reg  [31:0] rd_word;
  reg         rd_hit;

  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (rd_idx)
      `IDX_CONTROL:       rd_word = {16'h0000, control_register};
      `IDX_READ_SYNC:     rd_word = {16'h0000, 1'b0, read_cont, 8'h00,
                                     `RSYNC_ADDR_CONST}; // [R16]
      `IDX_EVENT_CTRL:    rd_word = {16'h0000, event_output_control};
      `IDX_IRQ_EN_CLR:    rd_word = {24'h000000, irq_enable};
      `IDX_IRQ_EN_SET:    rd_word = {24'h000000, irq_enable};
      `IDX_IRQ_FLAG:      rd_word = {24'h000000, irq_flag_status};
      `IDX_SYNC_STATUS:   rd_word = {24'h000000, sync_in_progress, 7'h00}; // [R15]
      `IDX_DEBUG_CTRL:    rd_word = {24'h000000, debug_control};
      `IDX_FREQ_CORR:     rd_word = {24'h000000, frequency_correction};
      `IDX_COUNTER_VALUE: begin
        rd_word = count_snapshot & wide_mask; // [R10] [R14]
        rd_hit  = wide_ok;
      end
      `IDX_COMPARE_0: begin
        rd_word = compare_value_0 & wide_mask; // [R14]
        rd_hit  = wide_ok;
      end
      default:            rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_hit ? rd_word : 32'h00000000;
      rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // rtc_counter_mode0

// >>> core/rtc_counter_regs.vh
// constants for the 32-bit real-time counter block
// assumes a word-addressed register bank: byte address = index * 4
`ifndef RTC_COUNTER_REGS_VH
`define RTC_COUNTER_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CONTROL        6'h00
`define IDX_READ_SYNC      6'h02
`define IDX_EVENT_CTRL     6'h04
`define IDX_IRQ_EN_CLR     6'h06
`define IDX_IRQ_EN_SET     6'h07
`define IDX_IRQ_FLAG       6'h08
`define IDX_SYNC_STATUS    6'h0a
`define IDX_DEBUG_CTRL     6'h0b
`define IDX_FREQ_CORR      6'h0c
`define IDX_COUNTER_VALUE  6'h10
`define IDX_COMPARE_0      6'h18

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_SOFTWARE_RESET_BIT         0
`define CTRL_ENABLE        1
`define CTRL_MODE_LO       2
`define CTRL_MODE_HI       3
`define CTRL_CLOCK_REPRESENTATION        6
`define CTRL_CLEAR_ON_MATCH      7
`define CTRL_PRESC_LO      8
`define CTRL_PRESC_HI      11
`define CTRL_WMASK         16'h0fce
`define MODE_COUNT32       2'h0
`define MODE_COUNT16       2'h1
`define MODE_CALENDAR      2'h2

// ----------------------------------------------------------------
// read sync, events, flags, status
// ----------------------------------------------------------------
`define RSYNC_RCONT        14
`define RSYNC_READ_SYNC_REQUEST         15
`define RSYNC_ADDR_CONST   6'h10
`define EVT_CMPEO0         8
`define EVT_OVERFLOW_EVENT_OUT          15
`define EVT_WMASK          16'h81ff
`define FLAG_COMPARE_MATCH_FLAG_0          0
`define FLAG_SYNC_DONE_FLAG       6
`define FLAG_OVF           7
`define FLAG_MASK          8'hc1
`define STAT_SYNC_IN_PROGRESS      7
`define DBG_WMASK          8'h01

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define RST_CONTROL        16'h0000
`define RST_EVENT_CTRL     16'h0000
`define RST_IRQ            8'h00
`define RST_WORD           32'h00000000
`define SYNC_CYCLES        2'h2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// >>> tb/rtc_counter_mode0_monitor.sv
// checker: bus answers, refusals and reset quieting of the counter block
// assumes it is bound into every instance of the top module
`timescale 1ns/100ps
`include "rtc_counter_regs.vh"
module rtc_counter_mode0_monitor (
  // clock and reset
  input wire        clk, srst,
  // write channels
  input wire [7:0]  awaddr,
  input wire        awvalid, awready, wvalid, wready, bvalid, bready,
  input wire [31:0] wdata,
  input wire [3:0]  wstrb,
  input wire [1:0]  bresp,
  // read channels
  input wire [7:0]  araddr,
  input wire        arvalid, arready, rvalid, rready,
  input wire [31:0] rdata,
  input wire [1:0]  rresp,
  // events and interrupt
  input wire [7:0]  periodic_event_out,
  input wire        compare_event_out, overflow_event_out, irq
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_wr; awvalid && wvalid && !bvalid; endsequence
  sequence s_rd; arvalid && !rvalid; endsequence
  sequence s_software_reset_bit;
    s_wr ##0 (awaddr[7:2] == `IDX_CONTROL && wstrb[0] && wdata[`CTRL_SOFTWARE_RESET_BIT]);
  endsequence
  a_write_answer: assert property (s_wr |=> bvalid)
    else $error("write not answered");
  a_read_answer: assert property (s_rd |=> rvalid)
    else $error("read not answered");
  a_resp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_data_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_ready_rule: assert property (awready == (awvalid && wvalid && !bvalid) && wready == awready
    && arready == !rvalid)
    else $error("ready mismatch");
  a_bad_write: assert property (s_wr ##0 awaddr[7:2] == 6'h01 |=> bresp == `RESP_SLVERR)
    else $error("unmapped write accepted");
  a_bad_read: assert property (s_rd ##0 araddr[7:2] == 6'h01 |=>
    rresp == `RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read accepted");
  a_sync_addr: assert property (s_rd ##0 araddr[7:2] == `IDX_READ_SYNC |=>
    rdata[5:0] == `RSYNC_ADDR_CONST)
    else $error("sync address wrong");
  // enables are gone after the reset, so nothing may be signalled
  a_software_reset_bit_quiet: assert property (s_software_reset_bit |-> ##3 (!irq && !compare_event_out
    && !overflow_event_out && periodic_event_out == 8'h00) [*2])
    else $error("output active after software reset");
endmodule // rtc_counter_mode0_monitor

bind rtc_counter_mode0 rtc_counter_mode0_monitor mon (.clk(clk), .srst(srst),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .periodic_event_out(periodic_event_out),
  .compare_event_out(compare_event_out), .overflow_event_out(overflow_event_out),
  .irq(irq));

// >>> tb/rtc_counter_mode0_tb_top.sv
// bench: register bank, counting, flags, irq and events of the counter
// assumes SRC_DIV of 1, so the counter ticks every 2^p clocks
`timescale 1ns/100ps
module rtc_counter_mode0_tb_top;
  // ----------
  // signals
  // ----------
  logic        clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, v, w, seed = 32'h60bc5daf;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  br, rr;
  wire         awready, wready, bvalid, arready, rvalid, irq, cmp_ev, ovf_ev;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  per_ev;
  int          err_total = 0, checks = 0, n_cmp = 0, n_ovf = 0, n_per = 0, i, p;
  logic [7:0]  map [9] = '{8'h00, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h28, 8'h2c, 8'h30, 8'h60};

  rtc_counter_mode0 #(.SRC_DIV(1)) dut (.clk(clk), .srst(srst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .periodic_event_out(per_ev), .compare_event_out(cmp_ev),
    .overflow_event_out(ovf_ev), .irq(irq));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    n_cmp <= n_cmp + cmp_ev;
    n_ovf <= n_ovf + ovf_ev;
    n_per <= n_per + per_ev[0];
  end
  // ----------
  // tasks
  // ----------
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [31:0] ticks(input int cyc, input int pr);
    ticks = cyc >> pr;
  endfunction
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 0;
    wvalid <= 0;
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 0;
    br = bresp;
  endtask
  task automatic rdw(input [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 0;
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 0;
    rd = rdata;
    rr = rresp;
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input [31:0] lo, input [31:0] hi, input [31:0] g);
    checks++;
    if (^g === 1'bx || g < lo || g > hi) begin
      err_total++;
      $display("CHECK FAILED %s exp %0d..%0d got %h", nm, lo, hi, g);
    end
  endtask
  task automatic chk_irq(input [31:0] e);
    repeat (2) @(posedge clk);
    chk("irq", e, irq);
  endtask
  // count reads give a snapshot, so refresh it first and wait off busy
  task automatic rd_count(output [31:0] c);
    int k;
    wr(8'h08, 32'h8000);
    k = 0;
    do rdw(8'h28); while (rd[7] !== 1'b0 && ++k < 20);
    rdw(8'h40);
    c = rd;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    report_and_stop;
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (6) @(posedge clk);
    srst <= 0;
    for (i = 0; i < 9; i++) begin
      rdw(map[i]);
      chk("reset", 0, rd);
    end
    rdw(8'h08);
    chk("sync addr", 32'h10, rd);
    rdw(8'h04);
    chk("bad rd", 2, rr);
    wr(8'h04, 32'hffffffff);
    chk("bad wr", 2, br);
    repeat (3) begin
      seed = lfsr(seed);
      wr(8'h40, seed);
      rd_count(v);
      chk("count rw", seed, v);
    end
    rdw(8'h20);
    chk("sync rdy", 32'h40, rd & 32'h40);
    for (p = 0; p < 5; p += 2) begin
      wr(8'h40, 0);
      wr(8'h00, p << 8);
      wr(8'h00, 2 | p << 8);
      repeat (64 << p) @(posedge clk);
      wr(8'h00, p << 8);
      rd_count(v);
      rng("rate", ticks(64 << p, p) - 1, ticks((64 << p) + 4, p) + 1, v);
      repeat (40) @(posedge clk);
      rd_count(w);
      chk("stopped", v, w);
    end
    wr(8'h20, 32'hff);
    wr(8'h60, 32'h80000000);
    wr(8'h10, 32'h8101);
    wr(8'h1c, 32'h80);
    wr(8'h40, 32'hfffffffd);
    w = n_ovf;
    wr(8'h00, 2);
    repeat (8) @(posedge clk);
    wr(8'h00, 0);
    rdw(8'h20);
    chk("ovf flag", 32'h80, rd & 32'h81);
    chk("ovf ev", 1, n_ovf - w);
    rd_count(v);
    rng("wrap", 4, 12, v);
    chk_irq(1);
    wr(8'h18, 32'h80);
    chk_irq(0);
    wr(8'h1c, 32'h80);
    chk_irq(1);
    wr(8'h20, 32'h80);
    chk_irq(0);
    wr(8'h20, 32'hff);
    wr(8'h40, 0);
    wr(8'h60, 20);
    wr(8'h00, 32'h80);
    w = n_cmp;
    wr(8'h00, 32'h82);
    repeat (100) @(posedge clk);
    wr(8'h00, 32'h80);
    rdw(8'h20);
    chk("match flags", 32'h81, rd & 32'h81);
    rng("cmp ev", 3, 6, n_cmp - w);
    rd_count(v);
    rng("cleared", 0, 20, v);
    wr(8'h20, 32'hff);
    wr(8'h40, 0);
    wr(8'h60, 5);
    wr(8'h00, 2);
    repeat (20) @(posedge clk);
    wr(8'h00, 0);
    rdw(8'h20);
    chk("cmp only", 1, rd & 32'h81);
    wr(8'h00, 32'h8);
    rdw(8'h40);
    chk("mode2", 2, rr);
    wr(8'h00, 0);
    rdw(8'h40);
    chk("mode0", 0, rr);
    wr(8'h2c, 1);
    wr(8'h00, 1);
    rdw(8'h10);
    chk("rst ev", 0, rd);
    rdw(8'h2c);
    chk("rst dbg", 1, rd);
    rng("per ev", 1, 100000, n_per);
    report_and_stop;
  end
endmodule // rtc_counter_mode0_tb_top
